// ### hdl/crsc_pkg.sv
// package for the class readout stage: constants, field layout and carrier types
//==============================================================================
// Functional notes
// RQ1 - average each class, find max, compare limit
// RQ2 - alert low until max exceeds limit
// RQ3 - force-alert raises alert every slow fall
// RQ4 - alert rises only at slow fall
// RQ5 - index pins update on alert or force
// RQ6 - index pins carry plain binary class
// RQ7 - accept events when enabled, destination 12
// RQ8 - two-bit selector maps address to class
// RQ9 - class hit only when average exceeds limit
// RQ10 - window 16 periods, 32 when long
// RQ11 - filter on by default, smoothing-off bypasses
// RQ12 - pin watch reports index and microsecond stamp
// RQ13 - window of 1, 16 or 32 periods
// RQ14 - 21-bit result word each slow cycle
// RQ15 - format 0 payload reads zero
// RQ16 - format 1 payload is per-class compare
// RQ17 - format 2 selected average, valid after compute
// RQ18 - format 3 max average plus compare
// RQ19 - one shared slow tick for all users
// RQ20 - internal slow clock counts 2^N events
// RQ21 - external slow clock stable, independent
// RQ22 - ties go to lowest class number
// RQ23 - pins hold between slow-clock updates
package crsc_pkg;
    //==========================================================================
    // sizes and timing
    localparam int          NCLASS      = 16;
    localparam int          CLK_NS      = 10;
    localparam int          US_NS       = 1000;
    localparam logic [6:0]  US_CYC_M1   = 7'(US_NS / CLK_NS - 1);
    localparam logic [3:0]  DEST_POST   = 4'hc;
    localparam logic [4:0]  DIV_MIN     = 5'h0e;
    localparam logic [4:0]  DIV_MAX     = 5'h11;
    localparam logic [2:0]  SH_ONE      = 3'h0;
    localparam logic [2:0]  SH_SHORT    = 3'h4;
    localparam logic [2:0]  SH_LONG     = 3'h5;
    //==========================================================================
    // register offsets (byte addresses) and reset values
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_LIMIT   = 8'h04;
    localparam logic [7:0]  OFS_RESULT  = 8'h08;
    localparam logic [7:0]  OFS_PINS    = 8'h0c;
    localparam logic [7:0]  OFS_STAMP   = 8'h10;
    localparam logic [31:0] CTRL_RST    = 32'h000e0000;
    localparam logic [15:0] LIMIT_RST   = 16'h0000;
    //==========================================================================
    // control field positions
    localparam int          B_ON        = 0;
    localparam int          B_FORCE     = 1;
    localparam int          B_LONG      = 2;
    localparam int          B_SMOFF     = 3;
    localparam int          B_WATCH     = 4;
    localparam int          B_INTCLK    = 5;
    localparam int          B_LAYOUT    = 6;
    localparam int          B_FMT       = 8;
    localparam int          B_SEL       = 10;
    localparam int          B_DIV       = 16;
    //==========================================================================
    // result word layout
    localparam int          R_VALID     = 20;
    localparam int          R_IDX       = 16;
    //==========================================================================
    // carrier types
    typedef struct packed {
        logic       valid;
        logic [3:0] dest;
        logic [1:0] x;
        logic [1:0] y;
        logic [3:0] f;
    } crsc_evt_s;

    typedef enum logic [1:0] {
        CRSC_FMT_OFF,
        CRSC_FMT_CMP,
        CRSC_FMT_SEL,
        CRSC_FMT_MAX
    } crsc_fmt_e;

    typedef struct packed {
        logic        alert;
        logic [3:0]  index;
        logic        rep_valid;
        logic [3:0]  rep_index;
        logic [31:0] rep_time;
    } crsc_pin_s;
endpackage : crsc_pkg

// ### hdl/crsc_slow_tick.sv
// slow clock source: internal dvs event divider or external level, one fall tick
`timescale 1ns/10ps
module crsc_slow_tick (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       int_sel,
    input  wire logic [4:0] div_exp,
    input  wire logic       dvs_evt,
    input  wire logic       ext_slow_clk,
    output logic            fall_tick
);
    import crsc_pkg::*;

    typedef struct packed {
        logic [16:0] evt_cnt;
        logic        ext_prev;
        logic        tick;
    } crsc_st_s;

    crsc_st_s st_ff;
    crsc_st_s nxt_st;
    logic [4:0]  exp_c;
    logic [16:0] last_c;

    //==========================================================================
    // divider and edge detect
    always_comb begin
        exp_c = (div_exp < DIV_MIN) ? DIV_MIN : ((div_exp > DIV_MAX) ? DIV_MAX : div_exp);
        last_c = 17'((18'h1 << exp_c) - 18'h1);
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        nxt_st.ext_prev = ext_slow_clk;
        if (int_sel) begin
            // one slow cycle per 2^N raw events [RQ20]
            if (dvs_evt) begin
                if (st_ff.evt_cnt >= last_c) begin
                    nxt_st.evt_cnt = '0;
                    nxt_st.tick = 1'b1;
                end else begin
                    nxt_st.evt_cnt = st_ff.evt_cnt + 17'h1;
                end
            end
        end else begin
            // outside logic owns the rate; only its falls are seen [RQ21]
            nxt_st.tick = st_ff.ext_prev & ~ext_slow_clk;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fall_tick = st_ff.tick;
endmodule : crsc_slow_tick

// ### hdl/crsc_class_map.sv
// event gate and address-to-class mapper, one register stage
`timescale 1ns/10ps
module crsc_class_map (
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    input  wire logic                enable,
    input  wire logic [1:0]          layout,
    input  wire crsc_pkg::crsc_evt_s evt,
    output logic                     cls_valid,
    output logic [3:0]               cls_idx
);
    import crsc_pkg::*;

    typedef struct packed {
        logic       valid;
        logic [3:0] idx;
    } crsc_map_s;

    crsc_map_s st_ff;
    crsc_map_s nxt_st;

    function automatic logic [3:0] map_class(input logic [1:0] sel, input crsc_evt_s e);
        unique case (sel)
            2'h0: map_class = {e.x[0], e.y[0], e.f[1:0]};
            2'h1: map_class = {e.x[0], e.y[1:0], e.f[0]};
            2'h2: map_class = {e.x[1:0], e.y[1:0]};
            2'h3: map_class = e.f;
        endcase
    endfunction : map_class

    //==========================================================================
    // gate and map
    always_comb begin
        nxt_st.valid = enable & evt.valid & (evt.dest == DEST_POST); // [RQ7]
        nxt_st.idx = map_class(layout, evt); // [RQ8]
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cls_valid = st_ff.valid;
    assign cls_idx = st_ff.idx;
endmodule : crsc_class_map

// ### hdl/crsc_readout.sv
// class readout stage top: averaging, max search, pins, result word, wishbone regs
`timescale 1ns/10ps
module crsc_readout (
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic                wb_we_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_cyc_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    input  wire crsc_pkg::crsc_evt_s evt_i,
    input  wire logic                dvs_evt,
    input  wire logic                ext_slow_clk,
    output logic                     slow_tick,
    output logic                     alert_pin,
    output logic [3:0]               class_index_pins,
    output logic [20:0]              per_tick_result,
    output logic                     pin_report_valid,
    output logic [3:0]               pin_index_report,
    output logic [31:0]              pin_report_time
);
    import crsc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SCAN,
        ST_EMIT
    } crsc_phase_e;

    typedef struct packed {
        crsc_phase_e             phase;
        logic [3:0]              idx;
        logic [NCLASS-1:0][15:0] cnt;
        logic [NCLASS-1:0][20:0] acc;
        logic [NCLASS-1:0]       cmp;
        logic [15:0]             max_avg;
        logic [3:0]              max_idx;
        logic [15:0]             sel_avg;
        logic [20:0]             result;
        crsc_pin_s               pins;
        logic                    tick;
        logic [6:0]              us_div;
        logic [31:0]             us_cnt;
        logic [31:0]             ctrl;
        logic [15:0]             limit;
        logic                    ack;
        logic [31:0]             rdat;
    } crsc_top_s;

    crsc_top_s st_ff;
    crsc_top_s nxt_st;
    logic      fall_tick;
    logic      cls_valid;
    logic [3:0] cls_idx;

    //==========================================================================
    // helpers
    function automatic logic [2:0] win_shift(input logic [31:0] c);
        // smoothing off gives a one-period window [RQ11] [RQ13]
        if (c[B_SMOFF]) begin
            win_shift = SH_ONE;
        end else if (c[B_LONG]) begin
            win_shift = SH_LONG; // [RQ10]
        end else begin
            win_shift = SH_SHORT; // [RQ10]
        end
    endfunction : win_shift

    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        lane_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                lane_merge[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
    endfunction : lane_merge

    //==========================================================================
    // submodules
    // the same tick would feed leak and dvs filters; no per-user clock choice [RQ19]
    crsc_slow_tick u_tick (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .int_sel      (st_ff.ctrl[B_INTCLK]),
        .div_exp      (st_ff.ctrl[B_DIV +: 5]),
        .dvs_evt      (dvs_evt),
        .ext_slow_clk (ext_slow_clk),
        .fall_tick    (fall_tick)
    );

    crsc_class_map u_map (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .enable    (st_ff.ctrl[B_ON]),
        .layout    (st_ff.ctrl[B_LAYOUT +: 2]),
        .evt       (evt_i),
        .cls_valid (cls_valid),
        .cls_idx   (cls_idx)
    );

    //==========================================================================
    // next state
    always_comb begin
        logic [15:0] cur;
        logic [20:0] acc_new;
        logic [15:0] avg;
        logic [2:0]  sh;
        logic        hit;
        logic [15:0] payload;
        cur = '0;
        acc_new = '0;
        avg = '0;
        sh = win_shift(st_ff.ctrl);
        hit = 1'b0;
        payload = '0;
        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        nxt_st.pins.rep_valid = 1'b0;
        nxt_st.tick = fall_tick;

        // microsecond time base for report stamps
        if (st_ff.us_div == US_CYC_M1) begin
            nxt_st.us_div = '0;
            nxt_st.us_cnt = st_ff.us_cnt + 32'h1;
        end else begin
            nxt_st.us_div = st_ff.us_div + 7'h1;
        end

        // saturating spike counts for the current slow period
        for (int i = 0; i < NCLASS; i++) begin
            if (cls_valid && cls_idx == 4'(i) && st_ff.cnt[i] != 16'hffff) begin
                nxt_st.cnt[i] = st_ff.cnt[i] + 16'h1;
            end
        end

        unique case (st_ff.phase)
            ST_IDLE: begin
                if (fall_tick && st_ff.ctrl[B_ON]) begin
                    nxt_st.phase = ST_SCAN;
                    nxt_st.idx = '0;
                    nxt_st.result[R_VALID] = 1'b0;
                end
            end
            ST_SCAN: begin
                // one class per cycle; a spike landing on the class being
                // drained starts the next period rather than being lost
                cur = st_ff.cnt[st_ff.idx];
                nxt_st.cnt[st_ff.idx] = (cls_valid && cls_idx == st_ff.idx) ? 16'h1 : 16'h0;
                acc_new = st_ff.acc[st_ff.idx] - (st_ff.acc[st_ff.idx] >> sh)
                          + {5'h00, cur}; // [RQ1]
                avg = 16'(acc_new >> sh);
                nxt_st.acc[st_ff.idx] = acc_new;
                nxt_st.cmp[st_ff.idx] = avg > st_ff.limit; // [RQ9]
                // strict compare keeps the lowest index on ties [RQ22]
                if (st_ff.idx == 4'h0 || avg > st_ff.max_avg) begin
                    nxt_st.max_avg = avg; // [RQ1]
                    nxt_st.max_idx = st_ff.idx;
                end
                if (st_ff.idx == st_ff.ctrl[B_SEL +: 4]) begin
                    nxt_st.sel_avg = avg;
                end
                if (st_ff.idx == 4'(NCLASS - 1)) begin
                    nxt_st.phase = ST_EMIT;
                end else begin
                    nxt_st.idx = st_ff.idx + 4'h1;
                end
            end
            ST_EMIT: begin
                nxt_st.phase = ST_IDLE;
                hit = st_ff.max_avg > st_ff.limit; // [RQ1]
                unique case (crsc_fmt_e'(st_ff.ctrl[B_FMT +: 2]))
                    CRSC_FMT_OFF: payload = '0; // [RQ15]
                    CRSC_FMT_CMP: payload = st_ff.cmp; // [RQ16]
                    CRSC_FMT_SEL: payload = st_ff.sel_avg; // [RQ17]
                    CRSC_FMT_MAX: payload = {hit, st_ff.max_avg[14:0]}; // [RQ18]
                endcase
                // valid only now, after every class is done [RQ14] [RQ17]
                nxt_st.result = {1'b1, st_ff.max_idx, payload};
                // alert and pins move only here, once per slow fall [RQ4] [RQ23]
                nxt_st.pins.alert = st_ff.ctrl[B_FORCE] | hit; // [RQ2] [RQ3]
                if (st_ff.ctrl[B_FORCE] || hit) begin
                    nxt_st.pins.index = st_ff.max_idx; // [RQ5] [RQ6]
                    if (st_ff.ctrl[B_WATCH]) begin
                        nxt_st.pins.rep_valid = 1'b1; // [RQ12]
                        nxt_st.pins.rep_index = st_ff.max_idx;
                        nxt_st.pins.rep_time = st_ff.us_cnt;
                    end
                end
            end
            default: begin
                nxt_st.phase = ST_IDLE;
            end
        endcase

        // wishbone classic slave, one wait state, ack held one cycle
        if (wb_cyc_i && wb_stb_i && !st_ff.ack) begin
            nxt_st.ack = 1'b1;
            nxt_st.rdat = '0;
            if (wb_we_i) begin
                if (wb_adr_i == OFS_CTRL) begin
                    nxt_st.ctrl = lane_merge(st_ff.ctrl, wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == OFS_LIMIT) begin
                    nxt_st.limit = 16'(lane_merge({16'h0000, st_ff.limit}, wb_dat_i, wb_sel_i));
                end
            end else begin
                unique case (wb_adr_i)
                    OFS_CTRL:   nxt_st.rdat = st_ff.ctrl;
                    OFS_LIMIT:  nxt_st.rdat = {16'h0000, st_ff.limit};
                    OFS_RESULT: nxt_st.rdat = {11'h000, st_ff.result};
                    OFS_PINS:   nxt_st.rdat = {27'h0000000, st_ff.pins.alert, st_ff.pins.index};
                    OFS_STAMP:  nxt_st.rdat = st_ff.pins.rep_time;
                    default:    nxt_st.rdat = '0;
                endcase
            end
        end
    end

    //==========================================================================
    // state register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
            st_ff.phase <= ST_IDLE;
            st_ff.ctrl <= CTRL_RST;
            st_ff.limit <= LIMIT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    //==========================================================================
    // outputs, all straight from the state register
    assign wb_dat_o = st_ff.rdat;
    assign wb_ack_o = st_ff.ack;
    assign slow_tick = st_ff.tick;
    assign alert_pin = st_ff.pins.alert;
    assign class_index_pins = st_ff.pins.index;
    assign per_tick_result = st_ff.result;
    assign pin_report_valid = st_ff.pins.rep_valid;
    assign pin_index_report = st_ff.pins.rep_index;
    assign pin_report_time = st_ff.pins.rep_time;
endmodule : crsc_readout

// ### testbench/crsc_readout_assertions.sv
// port-level checks for the class readout stage
`timescale 1ns/10ps
module crsc_readout_assertions (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        wb_stb_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_ack_o,
    input wire logic        slow_tick,
    input wire logic        alert_pin,
    input wire logic [3:0]  class_index_pins,
    input wire logic [20:0] per_tick_result,
    input wire logic        pin_report_valid,
    input wire logic [3:0]  pin_index_report
);
    //==========
    // handshake
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_once: assert property (s_req |=> s_ans)
        else $error("bus ack missing or too long");
    a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    //==========
    // pins and result word emitted 17 cycles after the tick; result valid drops with the tick
    a_alert_at_emit: assert property (
        $changed(alert_pin) |-> $past(slow_tick, 17))
        else $error("alert moved off the emit cycle");
    a_index_on_alert: assert property (
        $changed(class_index_pins) |-> alert_pin && $past(slow_tick, 17))
        else $error("index pins moved without alert");
    a_valid_after_scan: assert property (
        $rose(per_tick_result[20]) |-> $past(slow_tick, 17))
        else $error("result valid before scan done");
    a_valid_drop: assert property (
        $fell(per_tick_result[20]) |-> slow_tick || $past(slow_tick) || $past(slow_tick, 2))
        else $error("result valid dropped off tick");
    a_report_pulse: assert property (
        pin_report_valid |-> alert_pin ##1 !pin_report_valid)
        else $error("report pulse bad");
    a_report_index: assert property (
        pin_report_valid |-> pin_index_report == class_index_pins)
        else $error("report index differs from pins");
    a_result_index: assert property (
        $rose(per_tick_result[20]) && alert_pin |-> per_tick_result[19:16] == class_index_pins)
        else $error("result index differs from pins");
    a_tick_single: assert property (slow_tick |=> !slow_tick)
        else $error("slow tick longer than one cycle");
endmodule : crsc_readout_assertions

// ### testbench/crsc_host_model.sv
// far-side controller model: external slow clock and pin sampler
`timescale 1ns/10ps
module crsc_host_model #(
    parameter int HALF = 40
) (
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic       alert_pin,
    input wire logic [3:0] class_index_pins,
    output logic           ext_slow_clk,
    output logic [3:0]     seen_idx
);
    int cnt;
    //==========
    // free-running clock; pins read on its rise, far from the update edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt          <= 0;
            ext_slow_clk <= 1'b1;
            seen_idx     <= 4'h0;
        end else if (cnt == HALF - 1) begin
            cnt          <= 0;
            ext_slow_clk <= ~ext_slow_clk;
            if (!ext_slow_clk && alert_pin) seen_idx <= class_index_pins;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : crsc_host_model

// ### testbench/tb.sv
// self-checking bench for the class readout stage
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
$display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
    import crsc_pkg::*;
    //==========
    // signals
    logic sys_clk, resetn, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o, dvs_evt;
    logic ext_slow_clk, slow_tick, alert_pin, pin_report_valid;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, class_index_pins, pin_index_report, seen_idx, rep_idx;
    logic [31:0] wb_dat_i, wb_dat_o, rd, pin_report_time, rep_t, exp_t;
    logic [20:0] per_tick_result;
    crsc_evt_s evt_i;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [3:0] cls [4] = '{4'ha, 4'hd, 4'hb, 4'h8};
    logic [1:0] xs [4] = '{2'h1, 2'h1, 2'h2, 2'h0};
    logic [1:0] ys [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
    logic [3:0] fs [4] = '{4'h2, 4'h1, 4'h0, 4'h8};
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    crsc_readout crsc_readout_inst (.sys_clk(sys_clk), .resetn(resetn),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .evt_i(evt_i), .dvs_evt(dvs_evt), .ext_slow_clk(ext_slow_clk),
        .slow_tick(slow_tick), .alert_pin(alert_pin), .class_index_pins(class_index_pins),
        .per_tick_result(per_tick_result), .pin_report_valid(pin_report_valid),
        .pin_index_report(pin_index_report), .pin_report_time(pin_report_time));
    crsc_host_model #(.HALF(40)) crsc_host_model_inst (.sys_clk(sys_clk),
        .resetn(resetn), .alert_pin(alert_pin), .class_index_pins(class_index_pins),
        .ext_slow_clk(ext_slow_clk), .seen_idx(seen_idx));
    // cycles since reset release; the stamp counts whole microseconds of them
    always @(posedge sys_clk) begin
        if (resetn === 1'b1) cyc <= cyc + 1;
        if (pin_report_valid === 1'b1) begin
            rep_idx <= pin_index_report;
            rep_t   <= pin_report_time;
            exp_t   <= 32'((cyc - 1) / (US_NS / CLK_NS));
        end
    end
    //==========
    // helpers
    function automatic logic [31:0] cfg(input logic [5:0] b, input logic [1:0] lay,
                                        input logic [1:0] fmt, input logic [3:0] sel);
        cfg = {11'h0, DIV_MIN, 2'h0, sel, fmt, lay, b};
    endfunction : cfg
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        `CHK("bus ack", 1'b1, wb_ack_o)
    endtask : wb
    task automatic spikes(input int k, input logic [3:0] d, input logic [1:0] x,
                          input logic [1:0] y, input logic [3:0] f);
        repeat (k) begin
            @(posedge sys_clk);
            evt_i <= '{1'b1, d, x, y, f};
        end
        @(posedge sys_clk);
        evt_i.valid <= 1'b0;
    endtask : spikes
    // returns once the emit after the next slow tick has landed
    task automatic wait_emit;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (slow_tick !== 1'b1 && n < 400);
        `CHK("slow tick", 1'b1, slow_tick)
        repeat (18) @(posedge sys_clk);
    endtask : wait_emit
    //==========
    // scenarios
    task automatic t_regs;
        wb(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl reset", CTRL_RST, rd)
        wb(1'b0, OFS_LIMIT, 32'h0);
        `CHK("limit reset", 32'(LIMIT_RST), rd)
        wb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        wb(1'b1, OFS_LIMIT, 32'h0000ffff);
        wb(1'b0, OFS_LIMIT, 32'h0);
        `CHK("limit write", 32'h0000ffff, rd)
    endtask : t_regs
    task automatic t_force;
        wb(1'b1, OFS_CTRL, cfg(6'h03, 2'h0, 2'h0, 4'h0));
        wait_emit();
        wait_emit();
        `CHK("forced alert", 1'b1, alert_pin)
        `CHK("fmt0 word", {1'b1, 4'h0, 16'h0}, per_tick_result)
        wb(1'b1, OFS_CTRL, cfg(6'h01, 2'h0, 2'h1, 4'h0));
        wait_emit();
        `CHK("alert under limit", 1'b0, alert_pin)
        `CHK("fmt1 compare", 16'h0, per_tick_result[15:0])
    endtask : t_force
    // wrong-destination spikes would win if they were counted
    task automatic t_layouts;
        wb(1'b1, OFS_LIMIT, 32'h2);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, OFS_CTRL, cfg(6'h19, 2'(i), 2'h1, 4'h0));
            wait_emit();
            spikes(3, DEST_POST, xs[i], ys[i], fs[i]);
            spikes(5, 4'hb, 2'h0, 2'h0, 4'h0);
            wait_emit();
            `CHK("index pins", cls[i], class_index_pins)
            `CHK("alert", 1'b1, alert_pin)
            `CHK("compare bits", 16'h1 << cls[i], per_tick_result[15:0])
            `CHK("report index", cls[i], rep_idx)
            `CHK("report stamp", exp_t, rep_t)
            repeat (30) @(posedge sys_clk);
            `CHK("sampled index", cls[i], seen_idx)
        end
    endtask : t_layouts
    task automatic t_off;
        wb(1'b1, OFS_CTRL, cfg(6'h18, 2'h3, 2'h1, 4'h0));
        spikes(4, DEST_POST, 2'h0, 2'h0, 4'h5);
        repeat (130) @(posedge sys_clk);
        wb(1'b1, OFS_CTRL, cfg(6'h19, 2'h3, 2'h1, 4'h0));
        wait_emit();
        `CHK("gated spikes", 16'h0, per_tick_result[15:0])
        wb(1'b1, OFS_CTRL, cfg(6'h19, 2'h3, 2'h3, 4'h0));
        spikes(4, DEST_POST, 2'h0, 2'h0, 4'h5);
        wait_emit();
        `CHK("max word", {1'b1, 4'h5, 1'b1, 15'h4}, per_tick_result)
    endtask : t_off
    // clears the accumulator with smoothing off, then one period in mode b
    task automatic win(input logic [5:0] b, input int n, input logic [15:0] e);
        wb(1'b1, OFS_CTRL, cfg(6'h09, 2'h3, 2'h2, 4'h3));
        wait_emit();
        wb(1'b1, OFS_CTRL, cfg(b, 2'h3, 2'h2, 4'h3));
        spikes(n, DEST_POST, 2'h0, 2'h0, 4'h3);
        wait_emit();
        `CHK("selected average", e, per_tick_result[15:0])
    endtask : win
    task automatic t_intclk;
        int n;
        n = 0;
        wb(1'b1, OFS_CTRL, cfg(6'h21, 2'h3, 2'h0, 4'h0));
        repeat (4) @(posedge sys_clk);
        while (slow_tick !== 1'b1 && n < 40000) begin
            @(posedge sys_clk);
            dvs_evt <= ~dvs_evt;
            n++;
        end
        n = 0;
        do begin
            @(posedge sys_clk);
            dvs_evt <= ~dvs_evt;
            n += int'(dvs_evt);
        end while (slow_tick !== 1'b1 && n < 20000);
        `CHK("events per tick", 16384, n)
    endtask : t_intclk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    //==========
    // main sequence and watchdog
    initial begin
        resetn   = 1'b0;
        wb_we_i  = 1'b0;
        wb_stb_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_adr_i = 8'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hf;
        evt_i    = '0;
        dvs_evt  = 1'b0;
        rep_idx  = 4'h0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        t_regs();
        t_force();
        t_layouts();
        t_off();
        win(6'h01, 16, 16'h1);
        win(6'h05, 32, 16'h1);
        win(6'h09, 5, 16'h5);
        t_intclk();
        stop_test();
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        stop_test();
    end
endmodule : tb
bind crsc_readout crsc_readout_assertions crsc_readout_assertions_inst (
    .sys_clk(sys_clk), .resetn(resetn), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
    .wb_ack_o(wb_ack_o), .slow_tick(slow_tick), .alert_pin(alert_pin),
    .class_index_pins(class_index_pins), .per_tick_result(per_tick_result),
    .pin_report_valid(pin_report_valid), .pin_index_report(pin_index_report));
